// ==== eeac_pkg.sv ====
// package: register map, field layout and shared types of the eeprom and expander access block
package eeac_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_EEPROM_ACCESS_CTRL   = 12'h34C;
	localparam logic [11:0] OFS_EXPANDER_ACCESS_CTRL = 12'h350;
	localparam logic [11:0] OFS_IRQ_STATUS           = 12'h360;
	localparam logic [11:0] OFS_IRQ_MASK             = 12'h364;

	// ------------------------------------------------------------
	// eeprom register fields
	// ------------------------------------------------------------
	localparam int EE_ADDR_LSB = 0;
	localparam int EE_DATA_LSB = 16;
	localparam int EE_BUSY_BIT = 24;
	localparam int EE_DONE_BIT = 25;
	localparam int EE_OP_BIT   = 26;
	localparam logic EE_OP_WRITE = 1'h0;
	localparam logic EE_OP_READ  = 1'h1;

	// ------------------------------------------------------------
	// expander register fields
	// ------------------------------------------------------------
	localparam int IOE_DATA_LSB   = 0;
	localparam int IOE_RELOAD_BIT = 24;
	localparam int IOE_TM_BIT     = 25;
	localparam int IOE_SEL_LSB    = 26;
	localparam int IOE_DONE_BIT   = 31;
	localparam int IOE_COUNT      = 5;

	// ------------------------------------------------------------
	// interrupt bits and reset values
	// ------------------------------------------------------------
	localparam int IRQ_EE_BIT  = 0;
	localparam int IRQ_IOE_BIT = 1;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EEAC_RESP_OKAY   = 2'h0,
		EEAC_RESP_SLVERR = 2'h2
	} eeac_resp_t;

	typedef enum {EE_IDLE, EE_WAIT} eeac_ee_state_t;

	// one request to the two-wire engine
	typedef struct packed {
		logic        valid;
		logic        read;
		logic [15:0] addr;
		logic [7:0]  data;
	} eeac_ee_req_t;

	// one refresh/update request to the expander engine
	typedef struct packed {
		logic        valid;
		logic [2:0]  sel;
		logic [15:0] out_val;
	} eeac_ioe_req_t;

endpackage : eeac_pkg

// ==== eeac_access.sv ====
// module: axi4-lite register bank for eeprom byte access and i/o expander mirror
`timescale 1ns/10ps

// Contract
// R1 - writing data field launches one eeprom operation
// R2 - operation targets the 16-bit address field
// R3 - select bit zero writes, one reads
// R4 - write stores the written data byte
// R5 - read discards written byte, returns fetched byte
// R6 - busy reads one while operation runs
// R7 - done set on finish, write one clears
// R8 - each data bit maps one expander pin
// R9 - data reads show selected expander pin states
// R10 - data writes ignored unless test mode set
// R11 - test mode drives outputs from written data
// R12 - input bits stay read-only in every mode
// R13 - reload write starts expander refresh transaction
// R14 - reload bit always reads zero
// R15 - select codes 0,1,2,4 valid, others reserved
// R16 - test mode ignores core generated outputs
// R17 - expander done set on reload completion
// R18 - busy clears when done becomes set
// R19 - software waits for idle before relaunch
module eeac_access (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [11:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [11:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output eeac_pkg::eeac_ee_req_t       ee_req,
	input  wire logic                    ee_done,
	input  wire logic [7:0]              ee_rdata,
	output eeac_pkg::eeac_ioe_req_t      ioe_req,
	input  wire logic                    ioe_done,
	input  wire logic [15:0]             ioe_in_val,
	input  wire logic [15:0]             ioe_in_mask,
	input  wire logic [15:0]             core_out_val,
	output logic                         irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                    aw_held;
		logic [11:0]             aw_addr;
		logic                    w_held;
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		eeac_pkg::eeac_ee_state_t ee_state;
		logic [15:0]             ee_addr;
		logic [7:0]              ee_data;
		logic                    ee_op;
		logic                    ee_done_flag;
		eeac_pkg::eeac_ee_req_t  ee_req;
		logic [15:0]             ioe_tm_val;
		logic                    ioe_tm;
		logic [3:0]              ioe_sel;
		logic                    ioe_busy;
		logic                    ioe_done_flag;
		logic [15:0]             ioe_sent;
		logic [15:0]             ioe_fetched;
		eeac_pkg::eeac_ioe_req_t ioe_req;
		logic [1:0]              irq_status;
		logic [1:0]              irq_mask;
	} eeac_state_t;

	eeac_state_t st;
	eeac_state_t next_st;

	logic        wr_fire;
	logic        wr_hit_ee;
	logic        wr_hit_ioe;
	logic        wr_hit_sts;
	logic        wr_hit_msk;
	logic        sel_ok;
	logic [3:0]  eff_sel;
	logic        eff_tm;
	logic [31:0] wmask;
	logic [31:0] wd;
	logic [15:0] out_src;
	logic [15:0] pin_view;
	logic [1:0]  ev;
	logic [1:0]  clr;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = ~st.aw_held;
	assign s_axi_wready  = ~st.w_held;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign ee_req        = st.ee_req;
	assign ioe_req       = st.ioe_req;
	assign irq           = |(st.irq_status & st.irq_mask);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ee_req.valid  = 1'b0;
		next_st.ioe_req.valid = 1'b0;
		ev  = 2'h0;
		clr = 2'h0;

		// byte lane mask from strobes
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{st.w_strb[i]}};
		end
		wd = st.w_data;

		// select and mode written with a command apply to that command
		eff_sel = st.w_strb[3] ? wd[29:26] : st.ioe_sel;
		eff_tm  = st.w_strb[3] ? wd[eeac_pkg::IOE_TM_BIT] : st.ioe_tm;

		// only expanders 0,1,2,4 exist
		sel_ok = (eff_sel == 4'h0) || (eff_sel == 4'h1) ||
			(eff_sel == 4'h2) || (eff_sel == 4'h4); // R15

		// core outputs ignored in test mode
		out_src  = eff_tm ? st.ioe_tm_val : core_out_val; // R11 R16
		// inputs from fetched value, outputs from value last sent
		pin_view = (st.ioe_fetched & ioe_in_mask) | (st.ioe_sent & ~ioe_in_mask); // R8 R9 R12

		// write address and data taken in either order
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end

		wr_fire    = st.aw_held && st.w_held && !st.bvalid;
		wr_hit_ee  = wr_fire && (st.aw_addr[11:2] == eeac_pkg::OFS_EEPROM_ACCESS_CTRL[11:2]);
		wr_hit_ioe = wr_fire && (st.aw_addr[11:2] == eeac_pkg::OFS_EXPANDER_ACCESS_CTRL[11:2]);
		wr_hit_sts = wr_fire && (st.aw_addr[11:2] == eeac_pkg::OFS_IRQ_STATUS[11:2]);
		wr_hit_msk = wr_fire && (st.aw_addr[11:2] == eeac_pkg::OFS_IRQ_MASK[11:2]);

		if (wr_fire) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = (wr_hit_ee || wr_hit_ioe || wr_hit_sts || wr_hit_msk) ?
				eeac_pkg::EEAC_RESP_OKAY : eeac_pkg::EEAC_RESP_SLVERR;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// eeprom register write
		if (wr_hit_ee) begin
			if (st.w_strb[0]) begin
				next_st.ee_addr[7:0] = wd[7:0]; // R2
			end
			if (st.w_strb[1]) begin
				next_st.ee_addr[15:8] = wd[15:8]; // R2
			end
			if (st.w_strb[3]) begin
				next_st.ee_op = wd[eeac_pkg::EE_OP_BIT]; // R3
				if (wd[eeac_pkg::EE_DONE_BIT]) begin
					clr[eeac_pkg::IRQ_EE_BIT] = 1'b1; // R7
				end
			end
			// a data write while busy is dropped, not queued
			if (st.w_strb[2] && st.ee_state == eeac_pkg::EE_IDLE) begin // R1 R6
				next_st.ee_data      = wd[23:16]; // R4
				next_st.ee_state     = eeac_pkg::EE_WAIT; // R1 R6
				next_st.ee_req.valid = 1'b1; // R1
				next_st.ee_req.read  = st.w_strb[3] ? wd[eeac_pkg::EE_OP_BIT] : st.ee_op; // R3
				next_st.ee_req.addr  = {st.w_strb[1] ? wd[15:8] : st.ee_addr[15:8],
					st.w_strb[0] ? wd[7:0] : st.ee_addr[7:0]}; // R2
				next_st.ee_req.data  = wd[23:16]; // R4
			end
		end

		// eeprom engine
		case (st.ee_state)
			eeac_pkg::EE_IDLE: begin
			end
			eeac_pkg::EE_WAIT: begin
				if (ee_done) begin
					next_st.ee_state = eeac_pkg::EE_IDLE; // R18
					ev[eeac_pkg::IRQ_EE_BIT] = 1'b1; // R7 R18
					if (st.ee_req.read) begin
						next_st.ee_data = ee_rdata; // R5
					end
				end
			end
			default: begin
				next_st.ee_state = eeac_pkg::EE_IDLE;
			end
		endcase

		// expander register write
		if (wr_hit_ioe) begin
			if (st.w_strb[3]) begin
				next_st.ioe_tm  = wd[eeac_pkg::IOE_TM_BIT]; // R16
				next_st.ioe_sel = wd[29:26]; // R15
				if (wd[eeac_pkg::IOE_DONE_BIT]) begin
					clr[eeac_pkg::IRQ_IOE_BIT] = 1'b1; // R17
				end
			end
			// only output bits take the written value
			if (eff_tm && (st.w_strb[1:0] != 2'h0)) begin // R10
				next_st.ioe_tm_val = (st.ioe_tm_val & ~(wmask[15:0] & ~ioe_in_mask)) |
					(wd[15:0] & wmask[15:0] & ~ioe_in_mask); // R11 R12
				if (sel_ok && !st.ioe_busy) begin
					next_st.ioe_busy        = 1'b1;
					next_st.ioe_req.valid   = 1'b1; // R11
					next_st.ioe_req.sel     = eff_sel[2:0]; // R15
					next_st.ioe_req.out_val = next_st.ioe_tm_val;
				end
			end
			if (st.w_strb[3] && wd[eeac_pkg::IOE_RELOAD_BIT] && sel_ok && !st.ioe_busy) begin
				next_st.ioe_busy        = 1'b1;
				next_st.ioe_req.valid   = 1'b1; // R13
				next_st.ioe_req.sel     = eff_sel[2:0]; // R15
				next_st.ioe_req.out_val = out_src; // R13
			end
		end
		if (st.ioe_busy && ioe_done) begin
			next_st.ioe_busy    = 1'b0;
			next_st.ioe_sent    = st.ioe_req.out_val; // R9
			next_st.ioe_fetched = ioe_in_val; // R9 R13
			ev[eeac_pkg::IRQ_IOE_BIT] = 1'b1; // R17
		end

		// interrupt status and mask
		if (wr_hit_sts && st.w_strb[0]) begin
			clr = clr | wd[1:0];
		end
		if (wr_hit_msk && st.w_strb[0]) begin
			next_st.irq_mask = wd[1:0];
		end
		// set wins over a clear in the same cycle
		next_st.irq_status   = (st.irq_status & ~clr) | ev; // R7 R17
		next_st.ee_done_flag = next_st.irq_status[eeac_pkg::IRQ_EE_BIT]; // R7
		next_st.ioe_done_flag = next_st.irq_status[eeac_pkg::IRQ_IOE_BIT]; // R17

		// read channel
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = eeac_pkg::EEAC_RESP_OKAY;
			next_st.rdata  = 32'h0000_0000; // R14
			case (s_axi_araddr[11:2])
				eeac_pkg::OFS_EEPROM_ACCESS_CTRL[11:2]: begin
					next_st.rdata[15:0]  = st.ee_addr;
					next_st.rdata[23:16] = st.ee_data; // R5
					next_st.rdata[eeac_pkg::EE_BUSY_BIT] = (st.ee_state == eeac_pkg::EE_WAIT); // R6
					next_st.rdata[eeac_pkg::EE_DONE_BIT] = st.ee_done_flag; // R7
					next_st.rdata[eeac_pkg::EE_OP_BIT]   = st.ee_op;
				end
				eeac_pkg::OFS_EXPANDER_ACCESS_CTRL[11:2]: begin
					next_st.rdata[15:0]  = pin_view; // R9
					next_st.rdata[eeac_pkg::IOE_TM_BIT] = st.ioe_tm;
					next_st.rdata[29:26] = st.ioe_sel;
					next_st.rdata[eeac_pkg::IOE_DONE_BIT] = st.ioe_done_flag; // R17
				end
				eeac_pkg::OFS_IRQ_STATUS[11:2]: begin
					next_st.rdata[1:0] = st.irq_status;
				end
				eeac_pkg::OFS_IRQ_MASK[11:2]: begin
					next_st.rdata[1:0] = st.irq_mask;
				end
				default: begin
					next_st.rresp = eeac_pkg::EEAC_RESP_SLVERR;
				end
			endcase
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st          <= '0;
			st.ee_state <= eeac_pkg::EE_IDLE;
		end else begin
			st <= next_st;
		end
	end

endmodule : eeac_access

// ==== eeac_engine_model.sv ====
// partner: behavioural two-wire engine with eeprom store and expander pins
`timescale 1ns/10ps
module eeac_engine_model #(
	parameter int          DELAY  = 30,
	parameter logic [15:0] IN_PAT = 16'hA5C3
) (
	input  wire logic                    aclk,
	input  wire eeac_pkg::eeac_ee_req_t  ee_req,
	output logic                         ee_done,
	output logic [7:0]                   ee_rdata,
	input  wire eeac_pkg::eeac_ioe_req_t ioe_req,
	output logic                         ioe_done,
	output logic [15:0]                  ioe_in_val
);
	logic [7:0]             mem [0:65535];
	logic [15:0]            last_out;
	eeac_pkg::eeac_ee_req_t ee_hold;
	initial begin
		ee_done = 1'b0;
		ee_rdata = 8'h00;
		ioe_done = 1'b0;
		ioe_in_val = 16'h0000;
	end
	// ------------------------------------------------------------
	// eeprom: slow answer, data line inverted outside the done cycle
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (ee_req.valid === 1'b1) begin
			ee_hold = ee_req;
			repeat (DELAY) @(posedge aclk);
			if (!ee_hold.read) mem[ee_hold.addr] <= ee_hold.data;
			ee_rdata <= ee_hold.read ? mem[ee_hold.addr] : ~ee_rdata;
			ee_done <= 1'b1;
			@(posedge aclk);
			ee_done <= 1'b0;
			ee_rdata <= ~ee_rdata;
		end
	end
	// ------------------------------------------------------------
	// expander: pins valid only with the done pulse
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (ioe_req.valid === 1'b1) begin
			last_out <= ioe_req.out_val;
			repeat (DELAY / 2) @(posedge aclk);
			ioe_in_val <= IN_PAT;
			ioe_done <= 1'b1;
			@(posedge aclk);
			ioe_done <= 1'b0;
			ioe_in_val <= ~IN_PAT;
		end
	end
endmodule : eeac_engine_model

// ==== eeac_access_properties.sv ====
// checker: port-level properties of the eeprom and expander access block
`timescale 1ns/10ps
module eeac_access_properties (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [1:0]              s_axi_rresp,
	input wire eeac_pkg::eeac_ee_req_t  ee_req,
	input wire logic                    ee_done,
	input wire eeac_pkg::eeac_ioe_req_t ioe_req
);
	// ------------------------------------------------------------
	// helper: an eeprom operation is outstanding
	// ------------------------------------------------------------
	logic pend;
	always_ff @(posedge aclk) begin
		if (!aresetn) pend <= 1'b0;
		else if (ee_req.valid) pend <= 1'b1;
		else if (ee_done) pend <= 1'b0;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	ee_pulse_a: assert property (ee_req.valid |=> !ee_req.valid)
		else $error("eeprom request longer than one cycle");
	ee_single_a: assert property (ee_req.valid |-> !pend)
		else $error("eeprom launch while busy");
	ee_fields_a: assert property (!ee_req.valid |-> $stable(ee_req.addr) && $stable(ee_req.read))
		else $error("eeprom request fields moved");
	ioe_pulse_a: assert property (ioe_req.valid |=> !ioe_req.valid)
		else $error("expander request longer than one cycle");
	ioe_sel_a: assert property (ioe_req.valid |-> ioe_req.sel inside {3'h0, 3'h1, 3'h2, 3'h4})
		else $error("expander request to reserved select");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read with nonzero data");
endmodule : eeac_access_properties
bind eeac_access eeac_access_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_rresp, .ee_req, .ee_done, .ioe_req);

// ==== eeac_access_tb_top.sv ====
// testbench: register-level scenarios for the eeprom and expander access block
`timescale 1ns/10ps
module eeac_access_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, irq;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, last_bresp;
	logic        ee_done, ioe_done;
	logic [7:0]  ee_rdata;
	logic [15:0] ioe_in_val, ioe_in_mask = 16'hFF00, core_out_val = 16'h9966;
	eeac_pkg::eeac_ee_req_t  ee_req;
	eeac_pkg::eeac_ioe_req_t ioe_req;
	int          miscompares = 0, cmp_count = 0, ioe_cnt = 0;
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (ioe_req.valid === 1'b1) ioe_cnt++;
	eeac_access u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ee_req, .ee_done, .ee_rdata, .ioe_req, .ioe_done,
		.ioe_in_val, .ioe_in_mask, .core_out_val, .irq);
	eeac_engine_model u_model (.aclk, .ee_req, .ee_done, .ee_rdata, .ioe_req, .ioe_done,
		.ioe_in_val);
	// ------------------------------------------------------------
	// bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		bit aw_hit, w_hit, b_hit;
		b_hit = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// only the watchdog ends a wait for the answer
		while (!b_hit) begin
			@(negedge aclk);
			aw_hit = s_axi_awvalid && s_axi_awready;
			w_hit = s_axi_wvalid && s_axi_wready;
			b_hit = s_axi_bvalid && s_axi_bready;
			last_bresp = s_axi_bresp;
			@(posedge aclk);
			if (aw_hit) s_axi_awvalid <= 1'b0;
			if (w_hit) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		// one idle edge so a following call never re-raises bready in this step
		@(posedge aclk);
	endtask : axi_write
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar_hit, r_hit;
		r_hit = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_hit) begin
			@(negedge aclk);
			ar_hit = s_axi_arvalid && s_axi_arready;
			r_hit = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_hit) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, 32'h0);
	endtask : rd_chk
	// irq rises within a bound; a slow far side counts as a mismatch
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
	endtask : wait_irq
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_ee();
		rd_chk(12'h34C, 32'h0);
		axi_write(12'h364, 32'h3, 4'hF);
		axi_write(12'h34C, 32'h00A5_1234, 4'hF);
		chk({30'h0, last_bresp}, 32'h0);
		rd_chk(12'h34C, 32'h01A5_1234);
		wait_irq();
		rd_chk(12'h34C, 32'h02A5_1234);
		chk({24'h0, u_model.mem[16'h1234]}, 32'hA5);
		axi_write(12'h34C, 32'h0200_0000, 4'h8);
		chk({31'h0, irq}, 32'h0);
		axi_write(12'h34C, 32'h045A_1234, 4'hF);
		wait_irq();
		rd_chk(12'h34C, 32'h06A5_1234);
		axi_write(12'h34C, 32'h0600_0000, 4'h8);
	endtask : t_ee
	task automatic t_ioe();
		rd_chk(12'h350, 32'h0);
		axi_write(12'h350, 32'h0500_0000, 4'h8);
		wait_irq();
		rd_chk(12'h350, 32'h8400_A566);
		axi_write(12'h350, 32'h8400_0000, 4'h8);
		axi_write(12'h350, 32'h0000_1234, 4'h3);
		rd_chk(12'h350, 32'h0400_A566);
		chk(ioe_cnt, 32'h1);
		axi_write(12'h350, 32'h0600_3C3C, 4'hF);
		wait_irq();
		chk({24'h0, u_model.last_out[7:0]}, 32'h3C);
		rd_chk(12'h350, 32'h8600_A53C);
		axi_write(12'h350, 32'h8000_0000, 4'h8);
		axi_write(12'h350, 32'h0D00_0000, 4'h8);
		repeat (40) @(posedge aclk);
		chk(ioe_cnt, 32'h2);
	endtask : t_ioe
	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(12'h100, d, r);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		axi_write(12'h100, 32'h0000_00FF, 4'hF);
		chk({30'h0, last_bresp}, 32'h2);
	endtask : t_unmapped
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_ee();
		t_ioe();
		t_unmapped();
		complete_run();
	end
	// run needs a few hundred cycles; this bound only cuts a hang
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		complete_run();
	end
endmodule : eeac_access_tb_top
